// file: core/mcl_defines.svh
// timing counts, widths and reset values for the master configuration loader
`ifndef MCL_DEFINES_SVH
`define MCL_DEFINES_SVH

`define MCL_REF_KHZ          200000
`define MCL_FAST_MIN_KHZ     5000
`define MCL_FAST_MAX_KHZ     16670
`define MCL_SLOW_MIN_KHZ     630
`define MCL_SLOW_MAX_KHZ     2080
// half period in reference cycles, rounded up so the top of each range is never exceeded
`define MCL_HALF_CNT(max_khz) ((`MCL_REF_KHZ + 2 * (max_khz) - 1) / (2 * (max_khz)))
`define MCL_FAST_HALF        `MCL_HALF_CNT(`MCL_FAST_MAX_KHZ)
`define MCL_SLOW_HALF        `MCL_HALF_CNT(`MCL_SLOW_MAX_KHZ)
`define MCL_HALF_W           8

`define MCL_STROBE_PERIOD    8
`define MCL_STROBE_LOW       7
`define MCL_STROBE_CNT_W     3
`define MCL_SHIFT_SKIP_FALLS 1

`define MCL_ADDR_W           18
`define MCL_ADDR_RST         18'h0_0000
`define MCL_BYTE_CNT_W       24
`define MCL_SYNC_W           11

// wait that the host keeps after init rises, nanoseconds
`define MCL_INIT_TO_WRITE_DELAY_NS 2000

`endif

// file: core/mcl_pkg.sv
// types shared by the master configuration loader files
`include "mcl_defines.svh"

package mcl_pkg;

    typedef enum logic {
        MCL_MODE_SERIAL,
        MCL_MODE_PARALLEL
    } mcl_mode_t;

    typedef enum logic {
        MCL_ST_IDLE,
        MCL_ST_RUN
    } mcl_state_t;

    typedef struct packed {
        logic [`MCL_ADDR_W-1:0] addr;
        logic                   read_strobe;
    } mcl_mem_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } mcl_edge_t;

endpackage : mcl_pkg

// file: core/mcl_clkgen.sv
// config_clock divider with rise and fall event pulses in the reference domain
`timescale 1ns/1ps
`include "mcl_defines.svh"

module mcl_clkgen (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_run,
    input  wire logic [`MCL_HALF_W-1:0] i_half,
    output logic                        o_config_clock,
    output mcl_pkg::mcl_edge_t          o_edge
);
    import mcl_pkg::*;

    logic [`MCL_HALF_W-1:0] cnt_ff;
    logic                   config_clock_ff;
    logic [`MCL_HALF_W-1:0] nxt_cnt;
    logic                   nxt_config_clock;
    wire                    last_w = (cnt_ff == i_half - `MCL_HALF_W'(1));

    // stopping returns the clock low so a new run begins with a full low phase
    assign nxt_cnt  = (!i_run || last_w) ? '0 : cnt_ff + `MCL_HALF_W'(1);
    assign nxt_config_clock = !i_run ? 1'b0 : (last_w ? !config_clock_ff : config_clock_ff);

    // pulses mark the cycle whose edge moves the pin
    assign o_edge.rise    = i_run && last_w && !config_clock_ff;
    assign o_edge.fall    = i_run && last_w && config_clock_ff;
    assign o_config_clock = config_clock_ff;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff  <= '0;
            config_clock_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            config_clock_ff <= nxt_config_clock;
        end
    end

endmodule : mcl_clkgen

// file: core/mcl_loader.sv
// master serial and master parallel configuration loader
`timescale 1ns/1ps
`include "mcl_defines.svh"

// How it works
// RL1: serial bit sampled at each config_clock rise
// RL2: rate_select_pin low gives 5 to 16.67 MHz
// RL3: rate_select_pin high gives 0.63 to 2.08 MHz
// RL4: serial bit forwarded on following falling edge
// RL5: read strobe seven cycles low, one high
// RL6: new address per strobe, byte taken at rise
// RL7: byte shifted out 1.5 cycles after capture
// RL8: host waits 2 us after init before writing
// RL9: one oscillator, rate latched at start, divided
module mcl_loader (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_cfg_enable,
    input  wire logic                       i_rate_select_pin,
    input  wire logic                       i_mode_parallel_pin,
    input  wire logic                       i_serial_din,
    input  wire logic [7:0]                 i_mem_data,
    output logic                            o_config_clock,
    output mcl_pkg::mcl_mem_t               o_mem,
    output logic                            o_daisy_dout,
    output logic                            o_busy,
    output logic [`MCL_BYTE_CNT_W-1:0]      o_byte_count
);
    import mcl_pkg::*;

    // pin synchronisers
    logic [`MCL_SYNC_W-1:0] sync1_ff;
    logic [`MCL_SYNC_W-1:0] sync2_ff;
    wire  [`MCL_SYNC_W-1:0] pins_w = {i_rate_select_pin, i_mode_parallel_pin, i_serial_din, i_mem_data};

    wire        rate_slow_s = sync2_ff[10];
    wire        mode_par_s  = sync2_ff[9];
    wire        din_s       = sync2_ff[8];
    wire [7:0]  data_s      = sync2_ff[7:0];

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= pins_w;
            sync2_ff <= sync1_ff;
        end
    end

    // sequencing
    mcl_state_t state_ff;
    mcl_state_t nxt_state;
    mcl_mode_t  mode_ff;
    logic       rate_slow_ff;
    logic       enable_d_ff;

    wire start_w = i_cfg_enable && !enable_d_ff;
    wire run_w   = (state_ff == MCL_ST_RUN);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MCL_ST_IDLE: begin
                if (start_w) begin
                    nxt_state = MCL_ST_RUN;
                end
            end
            MCL_ST_RUN: begin
                if (!i_cfg_enable) begin
                    nxt_state = MCL_ST_IDLE;
                end
            end
            default: begin
                nxt_state = MCL_ST_IDLE;
            end
        endcase
    end

    // straps are caught at the start, so mid-run pin changes cannot jolt the clock
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff     <= MCL_ST_IDLE;
            mode_ff      <= MCL_MODE_SERIAL;
            rate_slow_ff <= 1'b0;
            enable_d_ff  <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            enable_d_ff <= i_cfg_enable;
            if (start_w) begin
                rate_slow_ff <= rate_slow_s; // RL9
                mode_ff      <= mode_par_s ? MCL_MODE_PARALLEL : MCL_MODE_SERIAL;
            end
        end
    end

    // clock generation
    mcl_edge_t              edge_w;
    wire [`MCL_HALF_W-1:0]  half_w;

    // RL2 RL3 RL9
    assign half_w = rate_slow_ff ? `MCL_HALF_W'(`MCL_SLOW_HALF) : `MCL_HALF_W'(`MCL_FAST_HALF);

    mcl_clkgen u_clkgen (
        .i_ref_clk      (i_ref_clk),
        .i_rst          (i_rst),
        .i_run          (run_w),
        .i_half         (half_w),
        .o_config_clock (o_config_clock),
        .o_edge         (edge_w)
    );

    wire serial_w = run_w && (mode_ff == MCL_MODE_SERIAL);
    wire par_w    = run_w && (mode_ff == MCL_MODE_PARALLEL);

    // serial path
    logic ser_bit_ff;
    logic ser_valid_ff;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ser_bit_ff   <= 1'b0;
            ser_valid_ff <= 1'b0;
        end else if (!serial_w) begin
            ser_valid_ff <= 1'b0;
        end else if (edge_w.rise) begin
            ser_bit_ff   <= din_s; // RL1
            ser_valid_ff <= 1'b1;
        end
    end

    // parallel path: strobe phase counter advances on each rise
    logic [`MCL_STROBE_CNT_W-1:0] phase_ff;
    logic [`MCL_ADDR_W-1:0]       addr_ff;
    logic                         strobe_ff;
    logic [7:0]                   hold_ff;
    logic                         pend_ff;
    logic                         skip_ff;

    wire [`MCL_STROBE_CNT_W-1:0] nxt_phase = phase_ff + `MCL_STROBE_CNT_W'(1);
    wire strobe_up_w   = par_w && edge_w.rise && (nxt_phase == `MCL_STROBE_CNT_W'(`MCL_STROBE_LOW));
    wire strobe_down_w = par_w && edge_w.rise && strobe_ff;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_ff  <= '0;
            strobe_ff <= 1'b0;
            addr_ff   <= `MCL_ADDR_RST;
        end else if (!par_w) begin
            phase_ff  <= '0;
            strobe_ff <= 1'b0;
            if (start_w) begin
                addr_ff <= `MCL_ADDR_RST;
            end
        end else if (edge_w.rise) begin
            phase_ff <= nxt_phase; // RL5
            if (strobe_up_w) begin
                strobe_ff <= 1'b1; // RL5
            end else if (strobe_down_w) begin
                strobe_ff <= 1'b0;
                addr_ff   <= addr_ff + `MCL_ADDR_W'(1); // RL6
            end
        end
    end

    // byte taken with the strobe rise, shift waits for the second fall
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_ff <= 8'h00;
            pend_ff <= 1'b0;
            skip_ff <= 1'b0;
        end else if (!par_w) begin
            pend_ff <= 1'b0;
            skip_ff <= 1'b0;
        end else if (strobe_up_w) begin
            hold_ff <= data_s; // RL6
            pend_ff <= 1'b1;
            skip_ff <= 1'b1;
        end else if (pend_ff && edge_w.fall) begin
            skip_ff <= 1'b0;
            if (!skip_ff) begin
                pend_ff <= 1'b0; // RL7
            end
        end
    end

    // shifter, most significant bit first
    logic [7:0] shift_ff;
    logic [3:0] left_ff;
    logic       dout_ff;
    logic [`MCL_BYTE_CNT_W-1:0] bytes_ff;

    wire load_w  = pend_ff && !skip_ff && edge_w.fall;
    wire shift_w = par_w && edge_w.fall && !load_w && (left_ff != 4'h0);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_ff <= 8'h00;
            left_ff  <= 4'h0;
            dout_ff  <= 1'b0;
        end else if (serial_w) begin
            left_ff <= 4'h0;
            if (edge_w.fall && ser_valid_ff) begin
                dout_ff <= ser_bit_ff; // RL4
            end
        end else if (!par_w) begin
            left_ff <= 4'h0;
        end else if (load_w) begin
            dout_ff  <= hold_ff[7]; // RL7
            shift_ff <= {hold_ff[6:0], 1'b0};
            left_ff  <= 4'h7;
        end else if (shift_w) begin
            dout_ff  <= shift_ff[7];
            shift_ff <= {shift_ff[6:0], 1'b0};
            left_ff  <= left_ff - 4'h1;
        end
    end

    // counts bytes in parallel mode, completed bytes of eight bits in serial mode
    logic [2:0] ser_bits_ff;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bytes_ff    <= '0;
            ser_bits_ff <= 3'h0;
        end else if (start_w) begin
            bytes_ff    <= '0;
            ser_bits_ff <= 3'h0;
        end else if (strobe_up_w) begin
            bytes_ff <= bytes_ff + `MCL_BYTE_CNT_W'(1);
        end else if (serial_w && edge_w.rise) begin
            ser_bits_ff <= ser_bits_ff + 3'h1;
            if (ser_bits_ff == 3'h7) begin
                bytes_ff <= bytes_ff + `MCL_BYTE_CNT_W'(1);
            end
        end
    end

    assign o_mem.addr        = addr_ff;
    assign o_mem.read_strobe = strobe_ff;
    assign o_daisy_dout      = dout_ff;
    assign o_busy            = run_w;
    assign o_byte_count      = bytes_ff;

endmodule : mcl_loader

// file: tb/mcl_loader_monitor.sv
// port checks for the master configuration loader
`timescale 1ns/1ps
`include "mcl_defines.svh"
module mcl_loader_monitor (
    input wire logic                       i_ref_clk,
    input wire logic                       i_rst,
    input wire logic                       i_cfg_enable,
    input wire logic                       i_rate_select_pin,
    input wire logic                       i_mode_parallel_pin,
    input wire logic                       i_serial_din,
    input wire logic [7:0]                 i_mem_data,
    input wire logic                       o_config_clock,
    input wire mcl_pkg::mcl_mem_t          o_mem,
    input wire logic                       o_daisy_dout,
    input wire logic                       o_busy,
    input wire logic [`MCL_BYTE_CNT_W-1:0] o_byte_count
);
    import mcl_pkg::*;
    logic       mode_ff, rate_ff, cc_d_ff, st_d_ff, bit_ff, bit_ok_ff, cap_ok_ff, prev_ok_ff;
    logic [6:0] cnt_ff;
    logic [2:0] rcnt_ff;
    logic [3:0] fidx_ff;
    logic [7:0] cur_ff, prev_ff;
    wire        rise = o_config_clock & ~cc_d_ff;
    wire        fall = ~o_config_clock & cc_d_ff;
    wire        srise = o_mem.read_strobe & ~st_d_ff;
    wire        sfall = ~o_mem.read_strobe & st_d_ff;
    // half periods of 6 and 49 reference cycles
    wire [6:0]  half_m1 = rate_ff ? 7'h30 : 7'h05;
    // first fall after a capture still carries bit 0 of the byte before
    wire        exp_par = (fidx_ff == 4'h0) ? prev_ff[0] : cur_ff[4'h8 - fidx_ff];

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            {mode_ff, rate_ff, cc_d_ff, st_d_ff, bit_ff, bit_ok_ff, cap_ok_ff, prev_ok_ff} <= 8'h00;
            {cnt_ff, rcnt_ff, fidx_ff, cur_ff, prev_ff} <= 30'h0000_0000;
        end else begin
            cc_d_ff <= o_config_clock;
            st_d_ff <= o_mem.read_strobe;
            cnt_ff <= (rise | fall) ? 7'h00 : cnt_ff + 7'h01;
            rcnt_ff <= (!o_busy | srise | sfall) ? 3'h0 : rcnt_ff + {2'h0, rise};
            fidx_ff <= srise ? 4'h0 : fidx_ff + {3'h0, fall};
            bit_ok_ff <= o_busy & (bit_ok_ff | rise);
            cap_ok_ff <= o_busy & (cap_ok_ff | srise);
            prev_ok_ff <= o_busy & (prev_ok_ff | (srise & cap_ok_ff));
            if (!o_busy) {mode_ff, rate_ff} <= {i_mode_parallel_pin, i_rate_select_pin};
            if (rise) bit_ff <= i_serial_din;
            if (srise) {cur_ff, prev_ff} <= {i_mem_data, cur_ff};
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_start;
        o_busy ##[1:60] rise;
    endsequence
    chk_half_high: assert property (fall && i_cfg_enable |-> cnt_ff == half_m1)
        else $error("clock high time wrong");
    chk_run_start: assert property ($rose(i_cfg_enable) |-> ##[1:2] s_start)
        else $error("run did not start");
    chk_strobe_high: assert property (srise |-> rcnt_ff == 3'h6 && rise)
        else $error("strobe low time wrong");
    chk_strobe_low: assert property (sfall && i_cfg_enable |-> rcnt_ff == 3'h0 && rise)
        else $error("strobe high time wrong");
    chk_strobe_due: assert property (mode_ff && o_busy && rise && rcnt_ff == 3'h6 |-> srise)
        else $error("strobe missing");
    chk_addr_step: assert property (o_busy && $past(o_busy) && i_cfg_enable
        |-> o_mem.addr == $past(o_mem.addr) + {17'h0_0000, sfall}) else $error("address step wrong");
    chk_serial_fwd: assert property (fall && !mode_ff && bit_ok_ff && i_cfg_enable
        |-> o_daisy_dout == bit_ff) else $error("serial forward wrong");
    chk_par_shift: assert property (fall && mode_ff && i_cfg_enable && cap_ok_ff && fidx_ff <= 4'h8
        && (fidx_ff != 4'h0 || prev_ok_ff) |-> o_daisy_dout == exp_par) else $error("byte shift wrong");
endmodule : mcl_loader_monitor

bind mcl_loader mcl_loader_monitor u_mcl_mon (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg_enable(i_cfg_enable),
    .i_rate_select_pin(i_rate_select_pin), .i_mode_parallel_pin(i_mode_parallel_pin),
    .i_serial_din(i_serial_din), .i_mem_data(i_mem_data), .o_config_clock(o_config_clock),
    .o_mem(o_mem), .o_daisy_dout(o_daisy_dout), .o_busy(o_busy), .o_byte_count(o_byte_count)
);

// file: tb/mcl_rom_model.sv
// behavioural configuration memory on the far side of the loader
`timescale 1ns/1ps
`include "mcl_defines.svh"
module mcl_rom_model (
    input  wire logic                   i_config_clock,
    input  wire logic                   i_busy,
    input  wire logic [`MCL_ADDR_W-1:0] i_addr,
    output logic                        o_serial_din,
    output logic [7:0]                  o_mem_data
);
    logic [20:0] idx_ff = 21'h00_0000;
    wire  [7:0]  sbyte = i_addr[7:0] ^ 8'hc3 ^ idx_ff[10:3];
    // next bit moves on the fall, a half period ahead of the sampling rise
    always @(negedge i_config_clock or negedge i_busy) begin
        idx_ff <= i_busy ? idx_ff + 21'h00_0001 : 21'h00_0000;
    end
    assign o_serial_din = sbyte[3'h7 - idx_ff[2:0]];
    assign o_mem_data = i_addr[7:0] ^ 8'hc3;
endmodule : mcl_rom_model

// file: tb/test_mcl_loader.sv
// self-checking bench for the master configuration loader
`timescale 1ns/1ps
`include "mcl_defines.svh"
module test_mcl_loader;
    import mcl_pkg::*;
    logic                       ref_clk = 1'b0;
    logic                       rst = 1'b1;
    logic                       en = 1'b0;
    logic                       rate = 1'b0;
    logic                       par = 1'b0;
    wire                        cc, dout, busy, din;
    wire  [7:0]                 mdata;
    mcl_mem_t                   mem;
    wire  [`MCL_BYTE_CNT_W-1:0] cnt;
    int                         n_mismatch = 0;
    int                         samples_checked = 0;
    int                         cyc = 0;

    mcl_loader uut (.i_ref_clk(ref_clk), .i_rst(rst), .i_cfg_enable(en), .i_rate_select_pin(rate),
        .i_mode_parallel_pin(par), .i_serial_din(din), .i_mem_data(mdata), .o_config_clock(cc),
        .o_mem(mem), .o_daisy_dout(dout), .o_busy(busy), .o_byte_count(cnt));
    mcl_rom_model u_rom (.i_config_clock(cc), .i_busy(busy), .i_addr(mem.addr),
        .o_serial_din(din), .o_mem_data(mdata));

    always #2.5 ref_clk = ~ref_clk;

    task automatic summarize;
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic chk(input bit ok, input string what);
        samples_checked++;
        if (!ok) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : chk

    // starts a run, flips the rate pin mid-run, stops after n strobes or clock rises
    task automatic run(input logic m, input logic r, input int n, input logic [`MCL_BYTE_CNT_W-1:0] ecnt,
                       input real lo, input real hi);
        realtime t0;
        @(negedge ref_clk);
        par = m;
        rate = r;
        repeat (4) @(negedge ref_clk);
        en = 1'b1;
        repeat (9) @(negedge ref_clk);
        rate = ~r;
        @(posedge cc);
        t0 = $realtime;
        @(posedge cc);
        chk($realtime - t0 >= lo && $realtime - t0 <= hi, "clock period");
        repeat (n) @(posedge (m ? mem.read_strobe : cc));
        repeat (3) @(negedge ref_clk);
        chk(cnt === ecnt, "byte count");
        if (m) chk(mem.addr === 18'(n - 1), "address");
        en = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({cc, mem.read_strobe} === 2'h0, "stop level");
    endtask : run

    task automatic t_par_fast;
        run(1'b1, 1'b0, 3, 24'h00_0003, 1.0e3 / 16.67, 1.0e3 / 5.00);
    endtask : t_par_fast
    task automatic t_par_slow;
        run(1'b1, 1'b1, 2, 24'h00_0002, 1.0e3 / 2.08, 1.0e3 / 0.63);
    endtask : t_par_slow
    task automatic t_ser_fast;
        run(1'b0, 1'b0, 17, 24'h00_0002, 1.0e3 / 16.67, 1.0e3 / 5.00);
    endtask : t_ser_fast
    task automatic t_ser_slow;
        run(1'b0, 1'b1, 8, 24'h00_0001, 1.0e3 / 2.08, 1.0e3 / 0.63);
    endtask : t_ser_slow

    // ceiling about six times the expected run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        // host-style settle after init before the first start request
        repeat (`MCL_INIT_TO_WRITE_DELAY_NS / 5) @(negedge ref_clk);
        t_par_fast();
        t_par_slow();
        t_ser_fast();
        t_ser_slow();
        summarize();
    end
endmodule : test_mcl_loader
